/* dv/tb_wtxr_regs.sv */
// Self-checking bench for the transmitter-mode register bank
// Assumes the power model supplies readings and receiver events
`timescale 1ns/1ps
module tb_wtxr_regs;
	import wtxr_pkg::*;
	localparam int MSC = 10;
	localparam logic [15:0] VIN = 16'h1388;
	localparam logic [15:0] VRC = 16'h1450;
	localparam logic [15:0] TMP = 16'h0029;
	localparam logic [9:0] RIX [9] = '{IDX_PINT, IDX_PDIV, IDX_PDUTY,
		IDX_OVP, IDX_UVP, IDX_FODL, IDX_FODH, IDX_FODB, IDX_OCP};
	localparam logic [15:0] RRV [9] = '{RST_PINT, RST_PDIV, {8'h00, RST_PDUTY},
		RST_OVP, RST_UVP, RST_FODL, RST_FODH, RST_FODB, RST_OCP};
	logic        mclk_i, nrst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdat;
	logic        wb_ack_o, cep_valid_i, maker_valid_i, sigstr_valid_i;
	logic        power_end_i, open_loop_o, open_loop_sync_o;
	logic        watchdog_en_o, packet_send_o, irq_clear_o;
	logic        ping_start_o, transmit_on_o;
	logic [15:0] vin_mv_i, vrect_mv_i, die_temp_i, maker_code_i;
	logic [15:0] rx_power_mw_i, ping_divisor_o, overvoltage_o;
	logic [15:0] undervoltage_o, overcurrent_o, fod_threshold_o;
	logic [7:0]  control_error_value_i, sigstr_value_i, ping_duty_o;
	int          mismatches, total_checks, cyc_n, n_sync, n_send;
	int          n_iclr, n_ping, last_ping, ping_gap, n_frz;

	wtxr_regs #(.MS_CYCLES(MSC)) i_dut (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.vin_mv_i(vin_mv_i), .vrect_mv_i(vrect_mv_i),
		.die_temp_i(die_temp_i), .cep_valid_i(cep_valid_i),
		.control_error_value_i(control_error_value_i), .maker_valid_i(maker_valid_i),
		.maker_code_i(maker_code_i), .sigstr_valid_i(sigstr_valid_i),
		.sigstr_value_i(sigstr_value_i), .power_end_i(power_end_i),
		.rx_power_mw_i(rx_power_mw_i), .open_loop_o(open_loop_o),
		.open_loop_sync_o(open_loop_sync_o),
		.watchdog_en_o(watchdog_en_o), .packet_send_o(packet_send_o),
		.irq_clear_o(irq_clear_o), .ping_start_o(ping_start_o),
		.transmit_on_o(transmit_on_o), .ping_divisor_o(ping_divisor_o),
		.ping_duty_o(ping_duty_o), .overvoltage_o(overvoltage_o),
		.undervoltage_o(undervoltage_o), .overcurrent_o(overcurrent_o),
		.fod_threshold_o(fod_threshold_o)
	);
	wtxr_pwr_model #(.VIN(VIN), .VRECT(VRC), .TEMP(TMP)) i_pwr (
		.mclk_i(mclk_i), .vin_mv_o(vin_mv_i), .vrect_mv_o(vrect_mv_i),
		.die_temp_o(die_temp_i), .cep_valid_o(cep_valid_i),
		.control_error_value_o(control_error_value_i), .maker_valid_o(maker_valid_i),
		.maker_code_o(maker_code_i), .sig_valid_o(sigstr_valid_i),
		.sig_value_o(sigstr_value_i), .power_end_o(power_end_i),
		.rx_power_o(rx_power_mw_i)
	);

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	// Pulse counters, ping spacing and run limit
	always @(posedge mclk_i) begin
		cyc_n <= cyc_n + 1;
		if (open_loop_sync_o === 1'b1) n_sync <= n_sync + 1;
		if (packet_send_o === 1'b1) n_send <= n_send + 1;
		if (irq_clear_o === 1'b1) n_iclr <= n_iclr + 1;
		if (ping_start_o === 1'b1) begin
			n_ping <= n_ping + 1;
			ping_gap <= cyc_n - last_ping;
			last_ping <= cyc_n;
		end
		if (cyc_n == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	// Classic single cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [9:0] ix,
		input logic [15:0] d);
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {ix, 2'b00};
		wb_dat_i <= {16'h0000, d};
		do begin
			@(posedge mclk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [9:0] ix,
		input logic [31:0] e);
		bus(1'b0, ix, 16'h0000);
		chk(nm, rdat, e);
	endtask

	initial begin
		nrst_i = 1'b0;
		ce_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'b1;
		rdc("status", IDX_STAT, 32'h2);
		rdc("cep", IDX_CEP, 32'h0);
		for (int i = 0; i < 9; i++) begin
			rdc("reset", RIX[i], {16'h0, RRV[i]});
			bus(1'b1, RIX[i], 16'hA5C3);
			rdc("rw", RIX[i], RIX[i] == IDX_PDUTY ? 32'hC3 : 32'hA5C3);
		end
		chk("ovp", overvoltage_o, 32'hA5C3);
		chk("uvp", undervoltage_o, 32'hA5C3);
		chk("ocp", overcurrent_o, 32'hA5C3);
		bus(1'b1, IDX_STAT, 16'h00FF);
		rdc("status", IDX_STAT, 32'h2);
		bus(1'b1, IDX_VIN, 16'h0000);
		rdc("vin", IDX_VIN, VIN);
		rdc("vrect", IDX_VRECT, VRC);
		rdc("temp", IDX_TEMP, TMP);
		rdc("unmapped", 10'h3FF, 32'h0);
		$display("test registers done");
		chk("ol", open_loop_o, 32'h0);
		bus(1'b1, IDX_CMD, 16'h8000);
		rdc("cmd", IDX_CMD, 32'h0);
		chk("ol", open_loop_o, 32'h1);
		bus(1'b1, IDX_CMD, 16'h0000);
		chk("ol", open_loop_o, 32'h1);
		bus(1'b1, IDX_CMD, 16'h401A);
		rdc("cmd", IDX_CMD, 32'h0);
		chk("sync", n_sync, 32'h1);
		chk("send", n_send, 32'h1);
		chk("iclr", n_iclr, 32'h1);
		chk("wd", watchdog_en_o, 32'h1);
		chk("ol", open_loop_o, 32'h1);
		$display("test commands done");
		bus(1'b1, IDX_PINT, 16'h0002);
		bus(1'b1, IDX_PDIV, 16'h1234);
		bus(1'b1, IDX_PDUTY, 16'h0033);
		bus(1'b1, IDX_CMD, 16'h0001);
		repeat (50) @(posedge mclk_i);
		rdc("status", IDX_STAT, 32'h1);
		chk("pings", n_ping >= 2, 32'h1);
		chk("gap", ping_gap, 2 * MSC);
		chk("div", ping_divisor_o, 32'h1234);
		chk("duty", ping_duty_o, 32'h33);
		chk("txon", transmit_on_o, 32'h1);
		$display("test ping done");
		i_pwr.ev_sig(8'h5A);
		rdc("status", IDX_STAT, 32'h8);
		rdc("sigstr", IDX_SIGSTR, 32'h5A);
		i_pwr.ev_cep(8'h9C);
		rdc("cep", IDX_CEP, 32'h9C);
		i_pwr.ev_maker(16'h1357);
		rdc("maker", IDX_MAKER, 32'h1357);
		i_pwr.ev_end();
		rdc("status", IDX_STAT, 32'h2);
		chk("txon", transmit_on_o, 32'h0);
		$display("test transfer done");
		bus(1'b1, IDX_CMD, 16'h0001);
		rdc("status", IDX_STAT, 32'h1);
		// Clock enable low: ping timer frozen, no ping may start
		ce_i <= 1'b0;
		n_frz = n_ping;
		repeat (40) @(posedge mclk_i);
		chk("frozen", n_ping, n_frz);
		chk("txon", transmit_on_o, 32'h1);
		ce_i <= 1'b1;
		bus(1'b1, IDX_CMD, 16'h0004);
		rdc("status", IDX_STAT, 32'h2);
		chk("wd", watchdog_en_o, 32'h0);
		chk("txon", transmit_on_o, 32'h0);
		$display("test disable done");
		bus(1'b1, IDX_FODL, 16'h0011);
		bus(1'b1, IDX_FODH, 16'hFF9C);
		bus(1'b1, IDX_FODB, 16'h0802);
		i_pwr.set_power(16'h0802);
		repeat (3) @(posedge mclk_i);
		chk("fod", fod_threshold_o, 32'h0011);
		i_pwr.set_power(16'h0803);
		repeat (3) @(posedge mclk_i);
		chk("fod", fod_threshold_o, 32'hFF9C);
		$display("test foreign object done");
		end_sim();
	end
endmodule

/* dv/wtxr_pwr_model.sv */
// Power stage and remote receiver model beside the register bank
// Assumes one bench process calls its event tasks at a time
`timescale 1ns/1ps
module wtxr_pwr_model #(
	parameter logic [15:0] VIN   = 16'h1388,
	parameter logic [15:0] VRECT = 16'h1450,
	parameter logic [15:0] TEMP  = 16'h0029
) (
	input  wire logic        mclk_i,
	output logic      [15:0] vin_mv_o,
	output logic      [15:0] vrect_mv_o,
	output logic      [15:0] die_temp_o,
	output logic             cep_valid_o,
	output logic      [7:0]  control_error_value_o,
	output logic             maker_valid_o,
	output logic      [15:0] maker_code_o,
	output logic             sig_valid_o,
	output logic      [7:0]  sig_value_o,
	output logic             power_end_o,
	output logic      [15:0] rx_power_o
);
	initial begin
		vin_mv_o = VIN;
		vrect_mv_o = VRECT;
		die_temp_o = TEMP;
		cep_valid_o = 1'b0;
		control_error_value_o = 8'h00;
		maker_valid_o = 1'b0;
		maker_code_o = 16'h0000;
		sig_valid_o = 1'b0;
		sig_value_o = 8'h00;
		power_end_o = 1'b0;
		rx_power_o = 16'h0000;
	end
	// One-cycle events; data inverted once released
	task automatic ev_cep(input logic [7:0] v);
		@(posedge mclk_i);
		cep_valid_o <= 1'b1;
		control_error_value_o <= v;
		@(posedge mclk_i);
		cep_valid_o <= 1'b0;
		control_error_value_o <= ~v;
	endtask
	task automatic ev_maker(input logic [15:0] v);
		@(posedge mclk_i);
		maker_valid_o <= 1'b1;
		maker_code_o <= v;
		@(posedge mclk_i);
		maker_valid_o <= 1'b0;
		maker_code_o <= ~v;
	endtask
	task automatic ev_sig(input logic [7:0] v);
		@(posedge mclk_i);
		sig_valid_o <= 1'b1;
		sig_value_o <= v;
		@(posedge mclk_i);
		sig_valid_o <= 1'b0;
		sig_value_o <= ~v;
	endtask
	task automatic ev_end;
		@(posedge mclk_i);
		power_end_o <= 1'b1;
		@(posedge mclk_i);
		power_end_o <= 1'b0;
	endtask
	task automatic set_power(input logic [15:0] v);
		@(posedge mclk_i);
		rx_power_o <= v;
	endtask
endmodule

/* rtl/wtxr_pkg.sv */
// Package for the transmitter-mode register bank
// Assumes a 25 MHz system clock and word-indexed register offsets
package wtxr_pkg;
	localparam int CLK_HZ   = 25_000_000;
	localparam int TICK_MS  = 1;
	localparam int MS_CYC   = CLK_HZ / 1000 * TICK_MS;
	localparam int REF_MHZ  = 60;
	localparam int IDX_W    = 10;
	localparam int ADR_W    = IDX_W + 2;

	localparam logic [IDX_W-1:0] IDX_CMD    = 10'h07C;
	localparam logic [IDX_W-1:0] IDX_STAT   = 10'h07E;
	localparam logic [IDX_W-1:0] IDX_VIN    = 10'h080;
	localparam logic [IDX_W-1:0] IDX_VRECT  = 10'h082;
	localparam logic [IDX_W-1:0] IDX_TEMP   = 10'h084;
	localparam logic [IDX_W-1:0] IDX_CEP    = 10'h0A5;
	localparam logic [IDX_W-1:0] IDX_MAKER  = 10'h0B0;
	localparam logic [IDX_W-1:0] IDX_SIGSTR = 10'h0D3;
	localparam logic [IDX_W-1:0] IDX_PINT   = 10'h0E0;
	localparam logic [IDX_W-1:0] IDX_PDIV   = 10'h0E2;
	localparam logic [IDX_W-1:0] IDX_PDUTY  = 10'h0E4;
	localparam logic [IDX_W-1:0] IDX_OVP    = 10'h0E8;
	localparam logic [IDX_W-1:0] IDX_UVP    = 10'h0EC;
	localparam logic [IDX_W-1:0] IDX_FODL   = 10'h0F8;
	localparam logic [IDX_W-1:0] IDX_FODH   = 10'h0FA;
	localparam logic [IDX_W-1:0] IDX_FODB   = 10'h0FC;
	localparam logic [IDX_W-1:0] IDX_OCP    = 10'h108;

	localparam int CMD_TGL   = 15;
	localparam int CMD_SYNC  = 14;
	localparam int CMD_WD    = 4;
	localparam int CMD_SEND  = 3;
	localparam int CMD_DIS   = 2;
	localparam int CMD_ICLR  = 1;
	localparam int CMD_LAUNCH = 0;
	localparam logic [15:0] CMD_MASK = 16'hC01F;

	localparam int STAT_XFER  = 3;
	localparam int STAT_READY = 1;
	localparam int STAT_PING  = 0;

	localparam logic [15:0] RST_CMD   = 16'h0000;
	localparam logic [7:0]  RST_STAT  = 8'h00;
	localparam logic [7:0]  RST_CEP   = 8'h00;
	localparam logic [15:0] RST_PINT  = 16'h04B0;
	localparam logic [15:0] RST_PDIV  = 16'h015F;
	localparam logic [7:0]  RST_PDUTY = 8'h4C;
	localparam logic [15:0] RST_OVP   = 16'h2AF8;
	localparam logic [15:0] RST_UVP   = 16'h1194;
	localparam logic [15:0] RST_FODL  = 16'h005A;
	localparam logic [15:0] RST_FODH  = 16'h005A;
	localparam logic [15:0] RST_FODB  = 16'h0802;
	localparam logic [15:0] RST_OCP   = 16'h09C4;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_READY,
		ST_PING,
		ST_XFER
	} wtxr_state_t;
endpackage

/* rtl/wtxr_regs.sv */
// Transmitter-mode register bank with phase sequencer, classic Wishbone
// Assumes synchronous inputs from the power stage and measurement logic
// Function
// - Toggle command flips open-loop mode, then the bit clears
// - Sync command applies open-loop parameters once, then clears
// - Watchdog command enables transmit watchdog, then clears
// - Send command transmits prepared packet, then clears
// - Disable command shuts transmitter down, then clears
// - Interrupt-clear command clears pending interrupts, then clears
// - Launch command starts digital ping, then clears
// - Transfer status bit set during power transfer, zero after reset
// - Ready status bit set while idle awaiting launch
// - Ping status bit set during digital ping phase
// - Input, rectifier voltage and die temperature read as 16-bit values
// - Last control error value held as signed byte, resets zero
// - Remote maker code held as read-only 16-bit field
// - Signal strength captured at start of power transfer
// - Pings spaced by programmed interval in milliseconds
// - Ping frequency is 60 MHz reference over programmed divisor
// - Programmed duty applied as initial duty at each ping
// - Writable undervoltage threshold in millivolts
// - Writable overvoltage threshold in millivolts
// - Foreign-object thresholds are signed 16-bit milliwatt values
// - High threshold used above boundary, low threshold otherwise
// - Writable overcurrent threshold in milliamperes
`timescale 1ns/1ps
module wtxr_regs #(
	parameter int MS_CYCLES = wtxr_pkg::MS_CYC
) (
	input  wire logic                        mclk_i,
	input  wire logic                        nrst_i,
	input  wire logic                        ce_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [wtxr_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [15:0]                 vin_mv_i,
	input  wire logic [15:0]                 vrect_mv_i,
	input  wire logic [15:0]                 die_temp_i,
	input  wire logic                        cep_valid_i,
	input  wire logic [7:0]                  control_error_value_i,
	input  wire logic                        maker_valid_i,
	input  wire logic [15:0]                 maker_code_i,
	input  wire logic                        sigstr_valid_i,
	input  wire logic [7:0]                  sigstr_value_i,
	input  wire logic                        power_end_i,
	input  wire logic [15:0]                 rx_power_mw_i,
	output logic                             open_loop_o,
	output logic                             open_loop_sync_o,
	output logic                             watchdog_en_o,
	output logic                             packet_send_o,
	output logic                             irq_clear_o,
	output logic                             ping_start_o,
	output logic                             transmit_on_o,
	output logic      [15:0]                 ping_divisor_o,
	output logic      [7:0]                  ping_duty_o,
	output logic      [15:0]                 overvoltage_o,
	output logic      [15:0]                 undervoltage_o,
	output logic      [15:0]                 overcurrent_o,
	output logic      [15:0]                 fod_threshold_o
);
	import wtxr_pkg::*;

	logic [15:0]              cmd_q;
	logic [7:0]               phase_status;
	logic [15:0]              vin_q;
	logic [15:0]              vrect_q;
	logic [15:0]              temp_q;
	logic [7:0]               cep_q;
	logic [15:0]              maker_q;
	logic [7:0]               sigstr_q;
	logic [15:0]              ping_interval_ms;
	logic [15:0]              ping_frequency_divisor;
	logic [7:0]               ping_initial_duty;
	logic [15:0]              fod_low;
	logic [15:0]              fod_high;
	logic [15:0]              fod_bound;
	logic [IDX_W-1:0]         idx;
	logic                     req;
	logic                     wr_en;
	logic                     cmd_wr;
	logic [15:0]              cmd_set;
	logic [31:0]              rd_data;
	logic [15:0]              ms_cnt;
	logic [15:0]              ms_elapsed;
	logic                     ms_tick;
	logic                     ping_due;
	wtxr_state_t              state;
	wtxr_state_t              next_state;

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	assign idx     = wb_adr_i[ADR_W-1:2];
	assign req     = wb_cyc_i && wb_stb_i;
	assign wr_en   = req && wb_we_i && wb_ack_o;
	assign cmd_wr  = wr_en && idx == IDX_CMD;
	// Only ones are taken; zeros leave pending commands alone
	assign cmd_set = cmd_wr ? merge16(16'h0000, wb_dat_i, wb_sel_i)
			& CMD_MASK : 16'h0000;

	// Bus answer, one wait state
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_ack_o <= req && !wb_ack_o;
			if (req && !wb_ack_o) begin
				wb_dat_o <= rd_data;
			end
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		case (idx)
			IDX_CMD:    rd_data[15:0] = cmd_q;
			IDX_STAT:   rd_data[7:0]  = phase_status;
			IDX_VIN:    rd_data[15:0] = vin_q;
			IDX_VRECT:  rd_data[15:0] = vrect_q;
			IDX_TEMP:   rd_data[15:0] = temp_q;
			IDX_CEP:    rd_data[7:0]  = cep_q;
			IDX_MAKER:  rd_data[15:0] = maker_q;
			IDX_SIGSTR: rd_data[7:0]  = sigstr_q;
			IDX_PINT:   rd_data[15:0] = ping_interval_ms;
			IDX_PDIV:   rd_data[15:0] = ping_frequency_divisor;
			IDX_PDUTY:  rd_data[7:0]  = ping_initial_duty;
			IDX_OVP:    rd_data[15:0] = overvoltage_o;
			IDX_UVP:    rd_data[15:0] = undervoltage_o;
			IDX_FODL:   rd_data[15:0] = fod_low;
			IDX_FODH:   rd_data[15:0] = fod_high;
			IDX_FODB:   rd_data[15:0] = fod_bound;
			IDX_OCP:    rd_data[15:0] = overcurrent_o;
			default:    rd_data = 32'h0000_0000;
		endcase
	end

	// Writable settings
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ping_interval_ms       <= RST_PINT;
			ping_frequency_divisor <= RST_PDIV;
			ping_initial_duty      <= RST_PDUTY;
			overvoltage_o          <= RST_OVP;
			undervoltage_o         <= RST_UVP;
			fod_low                <= RST_FODL;
			fod_high               <= RST_FODH;
			fod_bound              <= RST_FODB;
			overcurrent_o          <= RST_OCP;
		end else if (ce_i && wr_en) begin
			case (idx)
				IDX_PINT: ping_interval_ms <=
					merge16(ping_interval_ms, wb_dat_i, wb_sel_i);
				IDX_PDIV: ping_frequency_divisor <=
					merge16(ping_frequency_divisor, wb_dat_i, wb_sel_i);
				IDX_PDUTY: begin
					if (wb_sel_i[0]) begin
						ping_initial_duty <= wb_dat_i[7:0];
					end
				end
				IDX_OVP: overvoltage_o <=
					merge16(overvoltage_o, wb_dat_i, wb_sel_i);
				IDX_UVP: undervoltage_o <=
					merge16(undervoltage_o, wb_dat_i, wb_sel_i);
				IDX_FODL: fod_low <=
					merge16(fod_low, wb_dat_i, wb_sel_i);
				IDX_FODH: fod_high <=
					merge16(fod_high, wb_dat_i, wb_sel_i);
				IDX_FODB: fod_bound <=
					merge16(fod_bound, wb_dat_i, wb_sel_i);
				IDX_OCP: overcurrent_o <=
					merge16(overcurrent_o, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// Pending commands clear once acted on; a new set wins
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_q <= RST_CMD;
		end else if (ce_i) begin
			cmd_q <= cmd_set;
		end
	end

	// Command actions, one cycle after the bit is seen
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			open_loop_o      <= 1'b0;
			open_loop_sync_o <= 1'b0;
			watchdog_en_o    <= 1'b0;
			packet_send_o    <= 1'b0;
			irq_clear_o      <= 1'b0;
		end else if (ce_i) begin
			open_loop_o      <= open_loop_o ^ cmd_q[CMD_TGL];
			open_loop_sync_o <= cmd_q[CMD_SYNC];
			packet_send_o    <= cmd_q[CMD_SEND];
			irq_clear_o      <= cmd_q[CMD_ICLR];
			if (cmd_q[CMD_DIS]) begin
				watchdog_en_o <= 1'b0;
			end else if (cmd_q[CMD_WD]) begin
				watchdog_en_o <= 1'b1;
			end
		end
	end

	// Phase sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF:   next_state = ST_READY;
			ST_READY: begin
				if (cmd_q[CMD_LAUNCH]) begin
					next_state = ST_PING;
				end
			end
			ST_PING: begin
				if (sigstr_valid_i) begin
					next_state = ST_XFER;
				end
			end
			ST_XFER: begin
				if (power_end_i) begin
					next_state = ST_READY;
				end
			end
			default:  next_state = ST_OFF;
		endcase
		if (cmd_q[CMD_DIS] && state != ST_OFF) begin
			next_state = ST_READY;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state         <= ST_OFF;
			phase_status  <= RST_STAT;
			transmit_on_o <= 1'b0;
		end else if (ce_i) begin
			state        <= next_state;
			phase_status <= RST_STAT;
			phase_status[STAT_XFER]  <= next_state == ST_XFER;
			phase_status[STAT_READY] <= next_state == ST_READY;
			phase_status[STAT_PING]  <= next_state == ST_PING;
			transmit_on_o <= next_state == ST_PING || next_state == ST_XFER;
		end
	end

	// Ping spacing in milliseconds
	assign ms_tick  = ms_cnt == MS_LAST;
	assign ping_due = ms_tick && ms_elapsed + 16'h0001 >= ping_interval_ms;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ms_cnt         <= 16'h0000;
			ms_elapsed     <= 16'h0000;
			ping_start_o   <= 1'b0;
			ping_divisor_o <= RST_PDIV;
			ping_duty_o    <= RST_PDUTY;
		end else if (ce_i) begin
			ping_start_o <= 1'b0;
			if (state != ST_PING) begin
				ms_cnt     <= 16'h0000;
				ms_elapsed <= 16'h0000;
				if (next_state == ST_PING) begin
					ping_start_o <= 1'b1;
				end
			end else if (next_state == ST_PING) begin
				ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
				if (ping_due) begin
					ms_elapsed   <= 16'h0000;
					ping_start_o <= 1'b1;
				end else if (ms_tick) begin
					ms_elapsed <= ms_elapsed + 16'h0001;
				end
			end
			if (next_state == ST_PING && (state != ST_PING || ping_due)) begin
				ping_divisor_o <= ping_frequency_divisor;
				ping_duty_o    <= ping_initial_duty;
			end
		end
	end

	// Captured readings and link data
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vin_q    <= 16'h0000;
			vrect_q  <= 16'h0000;
			temp_q   <= 16'h0000;
			cep_q    <= RST_CEP;
			maker_q  <= 16'h0000;
			sigstr_q <= 8'h00;
		end else if (ce_i) begin
			vin_q   <= vin_mv_i;
			vrect_q <= vrect_mv_i;
			temp_q  <= die_temp_i;
			if (cep_valid_i) begin
				cep_q <= control_error_value_i;
			end
			if (maker_valid_i) begin
				maker_q <= maker_code_i;
			end
			if (state == ST_PING && sigstr_valid_i) begin
				sigstr_q <= sigstr_value_i;
			end
		end
	end

	// Foreign-object threshold selection
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fod_threshold_o <= RST_FODL;
		end else if (ce_i) begin
			fod_threshold_o <= rx_power_mw_i > fod_bound ?
				fod_high : fod_low;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	property p_toggle;
		ce_i && cmd_q[CMD_TGL] |=> open_loop_o != $past(open_loop_o);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("open loop did not toggle");

	property p_sync;
		ce_i && cmd_q[CMD_SYNC] |=> open_loop_sync_o;
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync pulse missing");

	property p_wd;
		ce_i && cmd_q[CMD_WD] && !cmd_q[CMD_DIS] |=> watchdog_en_o;
	endproperty
	a_wd: assert property (p_wd)
		else $error("watchdog not enabled");

	property p_send;
		ce_i && cmd_q[CMD_SEND] |=> packet_send_o ##1 !packet_send_o
			|| !ce_i;
	endproperty
	a_send: assert property (p_send)
		else $error("packet send pulse wrong");

	property p_dis;
		ce_i && cmd_q[CMD_DIS] && state != ST_OFF |=>
			state == ST_READY && !watchdog_en_o && phase_status == 8'h02;
	endproperty
	a_dis: assert property (p_dis)
		else $error("disable did not stop transmitter");

	property p_launch;
		ce_i && cmd_q[CMD_LAUNCH] && !cmd_q[CMD_DIS] && state == ST_READY |=>
			ping_start_o && phase_status[STAT_PING];
	endproperty
	a_launch: assert property (p_launch)
		else $error("launch did not start ping");

	property p_status;
		phase_status[STAT_XFER] |-> state == ST_XFER
			&& !phase_status[STAT_PING] && !phase_status[STAT_READY];
	endproperty
	a_status: assert property (p_status)
		else $error("transfer status inconsistent");

	property p_cmd_clear;
		ce_i && cmd_q != 16'h0000 && !cmd_wr |=> cmd_q == 16'h0000;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear)
		else $error("command bit not cleared");

	property p_cep;
		ce_i && cep_valid_i |=> cep_q == $past(control_error_value_i);
	endproperty
	a_cep: assert property (p_cep)
		else $error("control error not captured");

	property p_fod;
		ce_i |=> fod_threshold_o == ($past(rx_power_mw_i) >
			$past(fod_bound) ? $past(fod_high) : $past(fod_low));
	endproperty
	a_fod: assert property (p_fod)
		else $error("wrong foreign object threshold");

	c_launch: cover property (state == ST_READY ##1 state == ST_PING);
	c_xfer: cover property (state == ST_PING ##1 state == ST_XFER);
	c_reping: cover property (state == ST_PING && ping_due && ce_i);
endmodule
